// >>> rtl/osnr_pkg.sv
// Purpose: Shared constants of the oscillator SRAM/NVM/status register slice
// Assumes: Byte-wide register space behind a serial register engine
// Notes:   Offsets are register addresses of that space
package osnr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_FRAC_NUM_HI  = 8'h19;
  localparam logic [7:0] OFF_FRAC_NUM_MID = 8'h1A;
  localparam logic [7:0] OFF_FRAC_NUM_LO  = 8'h1B;
  localparam logic [7:0] OFF_NVM_CTRL     = 8'h31;
  localparam logic [7:0] OFF_MEM_PTR      = 8'h33;
  localparam logic [7:0] OFF_SRAM_DATA    = 8'h35;
  localparam logic [7:0] OFF_UNLOCK_KEY   = 8'h38;
  localparam logic [7:0] OFF_LIVE_STATUS  = 8'h42;
  localparam logic [7:0] OFF_SOFT_RESET   = 8'h48;
  // ==========================================================================
  // Values and field positions
  localparam logic [7:0] UNLOCK_KEY_VAL   = 8'hBE;
  localparam logic [7:0] BYTE_RST         = 8'h00;
  localparam logic [7:0] ADDR_STEP        = 8'h01;
  localparam int         LIVE_LOL_BIT     = 1;
  localparam int         LIVE_CAL_BIT     = 0;
  localparam int         SWR_PLL_BIT      = 1;
  localparam int         NVM_PROG_BIT     = 0;
  localparam int         NVM_ERASE_BIT    = 1;
  localparam int         NVM_BUSY_BIT     = 2;
  // ==========================================================================
  // Widths and depths
  localparam int         PTR_W            = 7;
  localparam int         SRAM_AW          = 5;
  localparam int         SRAM_DEPTH       = 32;
  localparam int         NUM_W            = 22;
  localparam int         FIFO_DEPTH       = 8;
  localparam int         FIFO_W           = SRAM_AW + 8;
  localparam logic [SRAM_AW-1:0] IDX_STEP = 5'h01;
  // Transaction tracking states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h1,
    TX_OPEN  = 3'h2,
    TX_BURST = 3'h4
  } osnr_txn_t;
endpackage

// >>> rtl/osnr_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes:   in_ready is registered, so a full FIFO refuses on the next edge
module osnr_fifo #(
  parameter int W = 13,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};
  localparam logic [AW:0] CNT_MAX = (AW+1)'(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          ready_q;
  wire           push = in_valid & ready_q;
  wire           pop  = out_valid & out_ready;

  // ==========================================================================
  // Occupancy; ready looks one edge ahead so it can come from a flop
  assign cnt_d = push & ~pop ? cnt_q + CNT_ONE :
                 pop & ~push ? cnt_q - CNT_ONE : cnt_q;
  assign in_ready  = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      wr_q    <= '0;
      rd_q    <= '0;
      ready_q <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      ready_q <= cnt_d < CNT_MAX;
      if (push) wr_q <= AW'(wr_q + 1'b1);
      if (pop) rd_q <= AW'(rd_q + 1'b1);
    end
  end

  // Storage needs no reset; entries are only read after being written
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule

// >>> rtl/osnr_regs.sv
// Purpose: SRAM burst port, NVM unlock/trigger, live PLL status, soft reset
//          and atomic fractional numerator update
// Assumes: A serial register engine presents one byte access per strobe
// Notes:   Summary of operation below
// Summary of operation
// - Byte-wide SRAM data port register supports reads and writes.
// - First SRAM port read of a transaction returns byte at start pointer.
// - First SRAM port write of a transaction stores byte at start pointer.
// - Later bytes of a transaction use next SRAM location; pointer unchanged.
// - Register address stops incrementing once the SRAM port is accessed.
// - Burst ends with the transaction; next transaction restarts at pointer.
// - Key must be written immediately before trigger, else no NVM cycle.
// - Key register is 8 bits, resets zero; only 0xBE arms.
// - Live status shows unlatched lock-lost in bit 1, calibrating in bit 0.
// - Soft reset bits clear themselves: one pulse per write with bit 1 set.
// - Soft reset register always reads zero.
// - Soft reset bit 1 resets PLL calibrator and dividers; others reserved.
// - Numerator applies as one whole value, never a partial one.
// - Only low five bits of the 7-bit start pointer address SRAM.
// - Triggers start only after a keyed prior transaction; they self-clear.
module osnr_regs
  import osnr_pkg::*;
(
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST_N,
  // Register access from the serial engine
  input  wire logic             TXN_START,
  input  wire logic             TXN_END,
  input  wire logic             ADDR_STB,
  input  wire logic [7:0]       ADDR,
  input  wire logic             WR_STB,
  input  wire logic [7:0]       WDATA,
  input  wire logic             RD_STB,
  output logic                  WR_READY,
  output logic [7:0]            RDATA,
  output logic                  RD_VALID,
  // PLL side
  input  wire logic             PLL_LOCK_LOST,
  input  wire logic             PLL_CAL_ACTIVE,
  output logic                  PLL_SOFT_RESET,
  output logic [NUM_W-1:0]      FRAC_NUM,
  output logic                  FRAC_NUM_LOAD,
  // NVM side
  input  wire logic             NVM_BUSY,
  output logic                  NVM_ERASE_START,
  output logic                  NVM_PROG_START
);
  // ==========================================================================
  // Decode helper, shared by write, read and address logic
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction

  osnr_txn_t            txn_q;
  logic [7:0]           cur_addr_q, rd_addr_q, key_q, mid_q, hi_q;
  logic [7:0]           rdata_q, live_q;
  logic [PTR_W-1:0]     ptr_q;
  logic [SRAM_AW-1:0]   burst_idx_q, rd_idx_q;
  logic [NUM_W-1:0]     num_q;
  logic [7:0]           mem_q [SRAM_DEPTH];
  logic                 rd_pend_q, rd_valid_q, key_ok_q, armed_q;
  logic                 swr_q, erase_q, prog_q, load_q;
  logic                 fifo_ready, fifo_valid;
  logic [FIFO_W-1:0]    fifo_out;

  // ==========================================================================
  // Access decode
  wire wr_take   = WR_STB & fifo_ready;
  wire rd_take   = RD_STB & ~rd_pend_q;
  wire access    = wr_take | rd_take;
  wire sram_hit  = hit(cur_addr_q, OFF_SRAM_DATA);
  wire sram_acc  = access & sram_hit;
  wire in_burst  = txn_q == TX_BURST;
  // Start pointer's top bits are kept but ignored for SRAM
  wire [SRAM_AW-1:0] acc_idx = in_burst ? burst_idx_q
                                        : ptr_q[SRAM_AW-1:0];
  wire wr_sram   = wr_take & sram_hit;
  wire wr_key    = wr_take & hit(cur_addr_q, OFF_UNLOCK_KEY);
  wire wr_nvm    = wr_take & hit(cur_addr_q, OFF_NVM_CTRL);
  wire wr_swr    = wr_take & hit(cur_addr_q, OFF_SOFT_RESET);
  wire key_match = WDATA == UNLOCK_KEY_VAL;
  // Reads of SRAM wait behind queued writes and any NVM busy period
  wire rd_done   = rd_pend_q & (~hit(rd_addr_q, OFF_SRAM_DATA) |
                                (~fifo_valid & ~NVM_BUSY));
  wire drain_rdy = ~NVM_BUSY;

  // ==========================================================================
  // Transaction tracking and burst lock
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      txn_q       <= TX_IDLE;
      burst_idx_q <= '0;
    end else begin
      unique case (txn_q)
        TX_IDLE, TX_OPEN: begin
          if (TXN_END) txn_q <= TX_IDLE;
          else if (sram_acc) txn_q <= TX_BURST;
          else if (TXN_START) txn_q <= TX_OPEN;
        end
        TX_BURST: begin
          if (TXN_END | TXN_START) txn_q <= TX_IDLE;
        end
      endcase
      if (sram_acc) burst_idx_q <= SRAM_AW'(acc_idx + IDX_STEP);
    end
  end

  // Register address: loaded by the engine, steps unless on the data port
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cur_addr_q <= BYTE_RST;
    end else if (ADDR_STB) begin
      cur_addr_q <= ADDR;
    end else if (access & ~sram_hit) begin
      cur_addr_q <= 8'(cur_addr_q + ADDR_STEP);
    end
  end

  // ==========================================================================
  // Write buffer in front of the SRAM; drain stalls while NVM is busy
  osnr_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .in_valid  (wr_sram),
    .in_ready  (fifo_ready),
    .in_data   ({acc_idx, WDATA}),
    .out_valid (fifo_valid),
    .out_ready (drain_rdy),
    .out_data  (fifo_out)
  );

  // One generate slice per SRAM byte, written from the buffer
  for (genvar i = 0; i < SRAM_DEPTH; i++) begin : g_sram
    wire wr_i = fifo_valid & drain_rdy &
                (fifo_out[FIFO_W-1:8] == SRAM_AW'(i));
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) mem_q[i] <= BYTE_RST;
      else if (wr_i) mem_q[i] <= fifo_out[7:0];
    end
  end

  // ==========================================================================
  // Simple registers: pointer, key, numerator staging
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ptr_q <= '0;
      key_q <= BYTE_RST;
      hi_q  <= BYTE_RST;
      mid_q <= BYTE_RST;
    end else if (wr_take) begin
      if (hit(cur_addr_q, OFF_MEM_PTR)) ptr_q <= WDATA[PTR_W-1:0];
      if (wr_key) key_q <= WDATA;
      if (hit(cur_addr_q, OFF_FRAC_NUM_HI)) hi_q <= WDATA;
      if (hit(cur_addr_q, OFF_FRAC_NUM_MID)) mid_q <= WDATA;
    end
  end

  // Numerator moves as one word on the low byte, so the divider
  // never sees a half-updated value while margining
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      num_q  <= '0;
      load_q <= 1'b0;
    end else begin
      load_q <= wr_take & hit(cur_addr_q, OFF_FRAC_NUM_LO);
      if (wr_take & hit(cur_addr_q, OFF_FRAC_NUM_LO)) begin
        num_q <= {hi_q[NUM_W-17:0], mid_q, WDATA};
      end
    end
  end

  // ==========================================================================
  // Unlock tracking: a key only arms the transaction right after it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      key_ok_q <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      if (TXN_START) key_ok_q <= 1'b0;
      else if (wr_key) key_ok_q <= key_match;
      else if (access) key_ok_q <= 1'b0;
      if (TXN_END) armed_q <= key_ok_q;
    end
  end

  // Trigger and soft reset bits are single pulses, never stored
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      erase_q <= 1'b0;
      prog_q  <= 1'b0;
      swr_q   <= 1'b0;
    end else begin
      erase_q <= wr_nvm & armed_q & WDATA[NVM_ERASE_BIT];
      prog_q  <= wr_nvm & armed_q & WDATA[NVM_PROG_BIT];
      swr_q   <= wr_swr & WDATA[SWR_PLL_BIT];
    end
  end

  // ==========================================================================
  // Read path; live bits are sampled each cycle, never latched
  wire [7:0] live_d = {6'h00, PLL_LOCK_LOST, PLL_CAL_ACTIVE};
  wire [7:0] rd_mux =
    hit(rd_addr_q, OFF_SRAM_DATA)    ? mem_q[rd_idx_q] :
    hit(rd_addr_q, OFF_MEM_PTR)      ? {1'b0, ptr_q} :
    hit(rd_addr_q, OFF_UNLOCK_KEY)   ? key_q :
    hit(rd_addr_q, OFF_LIVE_STATUS)  ? live_q :
    hit(rd_addr_q, OFF_NVM_CTRL)     ? 8'(NVM_BUSY) << NVM_BUSY_BIT :
    hit(rd_addr_q, OFF_FRAC_NUM_HI)  ? 8'(num_q[NUM_W-1:16]) :
    hit(rd_addr_q, OFF_FRAC_NUM_MID) ? num_q[15:8] :
    hit(rd_addr_q, OFF_FRAC_NUM_LO)  ? num_q[7:0] :
    BYTE_RST;                         // Soft reset, unmapped

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_pend_q  <= 1'b0;
      rd_addr_q  <= BYTE_RST;
      rd_idx_q   <= '0;
      rdata_q    <= BYTE_RST;
      rd_valid_q <= 1'b0;
      live_q     <= BYTE_RST;
    end else begin
      live_q     <= live_d;
      rd_valid_q <= rd_done;
      if (rd_done) rdata_q <= rd_mux;
      if (rd_take) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= cur_addr_q;
        rd_idx_q  <= acc_idx;
      end else if (rd_done) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign WR_READY        = fifo_ready;
  assign RDATA           = rdata_q;
  assign RD_VALID        = rd_valid_q;
  assign PLL_SOFT_RESET  = swr_q;
  assign FRAC_NUM        = num_q;
  assign FRAC_NUM_LOAD   = load_q;
  assign NVM_ERASE_START = erase_q;
  assign NVM_PROG_START  = prog_q;

  // ==========================================================================
  // Assertions
  sequence key_txn_s;
    wr_key & key_match & ~TXN_START ##1 ~access & ~TXN_START & TXN_END;
  endsequence

  key_arms_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    key_txn_s |=> armed_q)
    else $error("correct key did not arm");
  no_arm_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_nvm & ~armed_q |=> ~erase_q & ~prog_q)
    else $error("NVM cycle started without unlock");
  arm_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TXN_END & ~key_ok_q |=> ~armed_q)
    else $error("stale unlock survived a transaction");
  trig_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    prog_q & ~$past(wr_nvm) |-> 1'b0)
    else $error("program pulse without trigger write");
  swr_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_swr & WDATA[SWR_PLL_BIT] ##1 ~wr_swr |=> ~PLL_SOFT_RESET)
    else $error("soft reset held");
  swr_reads_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    rd_done & hit(rd_addr_q, OFF_SOFT_RESET) |=> RDATA == BYTE_RST)
    else $error("soft reset register read non-zero");
  first_sram_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sram_acc & ~in_burst |-> acc_idx == ptr_q[SRAM_AW-1:0])
    else $error("first SRAM access not at start pointer");
  burst_step_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sram_acc & ~ADDR_STB & ~wr_take |=>
      burst_idx_q == SRAM_AW'($past(acc_idx) + IDX_STEP) & $stable(ptr_q))
    else $error("burst address did not step");
  addr_lock_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sram_acc & ~ADDR_STB |=> cur_addr_q == OFF_SRAM_DATA)
    else $error("register address left the data port");
  live_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 live_q[LIVE_LOL_BIT] == $past(PLL_LOCK_LOST) &
        live_q[LIVE_CAL_BIT] == $past(PLL_CAL_ACTIVE))
    else $error("live status not current");

  // ==========================================================================
  // Burst, pointer and address checks
  burst_end_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    TXN_END |=> txn_q == TX_IDLE)
    else $error("burst survived the end of a transaction");
  ptr_index_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_take & sram_hit & ~in_burst |=> rd_idx_q == $past(ptr_q[SRAM_AW-1:0]))
    else $error("first SRAM read not at start pointer");
  first_write_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    wr_sram & ~in_burst & ~fifo_valid |=>
      fifo_out == {$past(ptr_q[SRAM_AW-1:0]), $past(WDATA)})
    else $error("first SRAM write not queued at start pointer");
  sram_land_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N) fifo_valid & drain_rdy |=>
      mem_q[$past(fifo_out[FIFO_W-1:8])] == $past(fifo_out[7:0]))
    else $error("queued SRAM write did not land");
  addr_step_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N) access & ~sram_hit & ~ADDR_STB
    |=> cur_addr_q == 8'($past(cur_addr_q) + ADDR_STEP))
    else $error("register address did not step");
  addr_load_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ADDR_STB |=> cur_addr_q == $past(ADDR))
    else $error("register address not loaded");

  // ==========================================================================
  // Soft reset, status, unlock and read strobe checks
  swr_mask_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ~(wr_swr & WDATA[SWR_PLL_BIT]) |=> ~PLL_SOFT_RESET)
    else $error("soft reset pulse without a set bit");
  swr_fire_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    wr_swr & WDATA[SWR_PLL_BIT] |=> PLL_SOFT_RESET)
    else $error("soft reset write gave no pulse");
  live_read_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_done & hit(rd_addr_q, OFF_LIVE_STATUS) |=> RDATA ==
      {6'h00, $past(PLL_LOCK_LOST, 2), $past(PLL_CAL_ACTIVE, 2)})
    else $error("live status read not current");
  key_store_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    wr_key |=> key_q == $past(WDATA))
    else $error("unlock key not stored");
  stale_key_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (access & ~wr_key) | (wr_key & ~key_match) |=> ~key_ok_q)
    else $error("key survived another access");
  trig_armed_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    NVM_ERASE_START | NVM_PROG_START |-> $past(armed_q) & $past(wr_nvm))
    else $error("NVM cycle started without an armed trigger write");
  rd_pulse_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RD_VALID |=> ~RD_VALID)
    else $error("read valid held longer than one cycle");

  // ==========================================================================
  // Numerator checks
  num_hold_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ~FRAC_NUM_LOAD |-> $stable(FRAC_NUM))
    else $error("numerator changed without a load");
  num_whole_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N) FRAC_NUM_LOAD |->
      FRAC_NUM == {$past(hi_q[NUM_W-17:0]), $past(mid_q), $past(WDATA)})
    else $error("numerator applied from mixed bytes");
endmodule

// >>> test/osnr_host_model.sv
// Purpose: Register-engine host that makes one byte access at a time
// Assumes: Every task is entered just after a rising clock edge
// Notes:   Unstrobed address and data lines toggle so stale values never pass
module osnr_host_model
  import osnr_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Requests to the device
  output logic            txn_start,
  output logic            txn_end,
  output logic            addr_stb,
  output logic [7:0]      addr,
  output logic            wr_stb,
  output logic [7:0]      wdata,
  output logic            rd_stb,
  // Answers from the device
  input  wire logic       wr_ready,
  input  wire logic [7:0] rdata,
  input  wire logic       rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hung = 1'b0;
  // ==========================================================================
  // Cycle driver
  // One call drives one cycle, so no line is assigned twice in a time step
  task automatic put(input logic ts, te, as, ws, rs, input logic [7:0] v);
    txn_start = ts;
    txn_end   = te;
    addr_stb  = as;
    addr      = as ? v : ~addr;
    wr_stb    = ws;
    wdata     = ws ? v : ~wdata;
    rd_stb    = rs;
    @(posedge clk);
    #1;
  endtask
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    put(0, 0, 0, 0, 0, 8'h00);
  end
  // ==========================================================================
  // Transaction framing and accesses
  task automatic begin_txn(input logic [7:0] a);
    put(1, 0, 0, 0, 0, 8'h00);
    put(0, 0, 1, 0, 0, a);
  endtask
  task automatic end_txn();
    put(0, 1, 0, 0, 0, 8'h00);
  endtask
  // Write held until the edge that sees the device ready
  task automatic wr(input logic [7:0] d);
    int n;
    n = 0;
    while (wr_ready !== 1'b1 && n < 200) begin
      put(0, 0, 0, 1, 0, d);
      n++;
    end
    if (wr_ready !== 1'b1) hung = 1'b1;
    put(0, 0, 0, 1, 0, d);
  endtask
  // Read pulse, then bounded wait for the answer strobe
  task automatic rd(output logic [7:0] d);
    int n;
    n = 0;
    put(0, 0, 0, 0, 1, 8'h00);
    while (rd_valid !== 1'b1 && n < 200) begin
      put(0, 0, 0, 0, 0, 8'h00);
      n++;
    end
    if (rd_valid !== 1'b1) hung = 1'b1;
    d = rdata;
  endtask
  // Key written alone in its own transaction, right before a trigger
  task automatic arm();
    begin_txn(OFF_UNLOCK_KEY);
    wr(UNLOCK_KEY_VAL);
    end_txn();
  endtask
endmodule

// >>> test/tb_osnr_regs.sv
// Purpose: Self-checking bench of the SRAM port, unlock, status and reset
// Assumes: Host model drives the register side; bench drives PLL and NVM
// Notes:   Random bytes come from a fixed-seed shift register
module tb_osnr_regs
  import osnr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk_sys = 1'b0;
  logic             rst_n, txn_start, txn_end, addr_stb, wr_stb, rd_stb;
  logic [7:0]       addr, wdata, rdata, v, ptr;
  logic             wr_ready, rd_valid, pll_lock_lost, pll_cal_active;
  logic             pll_soft_reset, frac_num_load, nvm_busy;
  logic             nvm_erase_start, nvm_prog_start, saw_full = 1'b0;
  logic [NUM_W-1:0] frac_num, num_q = '0, nv;
  logic [7:0]       mem [32];
  logic [4:0]       ix;
  logic [31:0]      seed = 32'h21D0;
  int               error_cnt = 0, cmp_count = 0, n_swr = 0, n_prog = 0;
  int               n_ers = 0, n_load = 0, e_swr = 0, p0, e0;
  always #5 clk_sys = ~clk_sys;
  osnr_regs DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .TXN_START(txn_start),
    .TXN_END(txn_end), .ADDR_STB(addr_stb), .ADDR(addr), .WR_STB(wr_stb),
    .WDATA(wdata), .RD_STB(rd_stb), .WR_READY(wr_ready), .RDATA(rdata),
    .RD_VALID(rd_valid), .PLL_LOCK_LOST(pll_lock_lost),
    .PLL_CAL_ACTIVE(pll_cal_active), .PLL_SOFT_RESET(pll_soft_reset),
    .FRAC_NUM(frac_num), .FRAC_NUM_LOAD(frac_num_load), .NVM_BUSY(nvm_busy),
    .NVM_ERASE_START(nvm_erase_start), .NVM_PROG_START(nvm_prog_start));
  osnr_host_model host (.clk(clk_sys), .txn_start(txn_start),
    .txn_end(txn_end), .addr_stb(addr_stb), .addr(addr), .wr_stb(wr_stb),
    .wdata(wdata), .rd_stb(rd_stb), .wr_ready(wr_ready), .rdata(rdata),
    .rd_valid(rd_valid));
  // ==========================================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, g);
    cmp_count++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a, e, input string nm);
    logic [7:0] d;
    host.begin_txn(a);
    host.rd(d);
    host.end_txn();
    chk(nm, e, d);
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    host.begin_txn(a);
    host.wr(d);
    host.end_txn();
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge host.hung) begin
    error_cnt++;
    test_done();
  end
  // ==========================================================================
  // Output monitor: pulse counts, refusal seen, numerator only moves whole
  always @(posedge clk_sys) begin
    #2;
    n_swr  += (pll_soft_reset === 1'b1);
    n_prog += (nvm_prog_start === 1'b1);
    n_ers  += (nvm_erase_start === 1'b1);
    n_load += (frac_num_load === 1'b1);
    if (wr_ready === 1'b0) saw_full = 1'b1;
    chk("frac_num", frac_num_load === 1'b1 ? nv : num_q, frac_num);
    num_q = frac_num;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    pll_lock_lost = 1'b0;
    pll_cal_active = 1'b0;
    nvm_busy = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    rd_reg(OFF_UNLOCK_KEY, 8'h00, "key_reset");
    // Live status follows each input pair, upper bits zero
    for (int i = 0; i < 4; i++) begin
      pll_lock_lost = i[1];
      pll_cal_active = i[0];
      rd_reg(OFF_LIVE_STATUS, {6'h00, i[1:0]}, "live_status");
    end
    pll_lock_lost = 1'b0;
    pll_cal_active = 1'b0;
    // Soft reset: random bytes, one pulse per write with bit 1 set
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      v[1] = (i < 4) ? ~v[1] : v[1];
      e_swr += v[1];
      wr_reg(OFF_SOFT_RESET, v);
    end
    repeat (3) @(posedge clk_sys);
    #1;
    chk("swr_pulses", e_swr, n_swr);
    rd_reg(OFF_SOFT_RESET, 8'h00, "swr_read");
    // Pointer with bits 6:5 set; only bits 4:0 may address the array
    v = rnd();
    ptr = {1'b0, 2'h3, v[4:0]};
    wr_reg(OFF_MEM_PTR, ptr);
    // Stalled drain fills the queue until writes are refused
    nvm_busy = 1'b1;
    fork
      begin
        repeat (60) @(posedge clk_sys);
        #1;
        nvm_busy = 1'b0;
      end
    join_none
    host.begin_txn(OFF_SRAM_DATA);
    for (int i = 0; i < 10; i++) begin
      v = rnd();
      ix = ptr[4:0] + i[4:0];
      mem[ix] = v;
      host.wr(v);
    end
    host.end_txn();
    chk("queue_refused", 1'b1, saw_full);
    // Read burst entered from the address below the port by increment
    host.begin_txn(OFF_SRAM_DATA - 8'h01);
    host.rd(v);
    chk("unmapped", 8'h00, v);
    for (int i = 0; i < 10; i++) begin
      ix = ptr[4:0] + i[4:0];
      host.rd(v);
      chk("sram_burst", mem[ix], v);
    end
    host.end_txn();
    rd_reg(OFF_SRAM_DATA, mem[ptr[4:0]], "sram_restart");
    rd_reg(OFF_MEM_PTR, ptr, "ptr_kept");
    // Unlock table: prog, erase, wrong key, stale key, no key
    for (int k = 0; k < 5; k++) begin
      p0 = n_prog;
      e0 = n_ers;
      if (k < 2 || k == 3) host.arm();
      if (k == 2) wr_reg(OFF_UNLOCK_KEY, UNLOCK_KEY_VAL ^ (rnd() | 8'h01));
      if (k == 3) rd_reg(OFF_LIVE_STATUS, 8'h00, "live_between");
      wr_reg(OFF_NVM_CTRL, k == 1 ? 8'h02 : 8'h01);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("prog_starts", k == 0, n_prog - p0);
      chk("erase_starts", k == 1, n_ers - e0);
    end
    // Numerator written in three bytes, applied once as a whole
    v = rnd();
    nv = {v[5:0], rnd(), rnd()};
    host.begin_txn(OFF_FRAC_NUM_HI);
    host.wr({2'b00, nv[21:16]});
    host.wr(nv[15:8]);
    host.wr(nv[7:0]);
    host.end_txn();
    repeat (3) @(posedge clk_sys);
    #1;
    chk("frac_value", nv, frac_num);
    chk("frac_loads", 1, n_load);
    test_done();
  end
endmodule
